/* src/qwp_spi_slave.sv */
// Quad wiper register slave: frame execution, registers and tap switching
//
// Function
// - Mode 0; inputs sampled on rising clock, output changed on falling.
// - Every byte travels most significant bit first.
// - First byte is instruction: three opcode bits, five address bits.
// - Address 0..3 selects a wiper register, address 10000 access control.
// - Opcodes: nop, access read, access write, register read, register write.
// - Write frame: instruction, data bytes; applied when chip select rises.
// - Third byte out is the echo byte, fourth byte returns register data.
// - Traffic ignored after reset until a chip select falling edge.
// - Deselected: output released, standby, no shifting.
// - Access bit 1 chooses push-pull (0) or open-drain (1) output.
// - Access bit 6 low shuts all four channels down.
// - Shutdown keeps wiper codes; leaving it restores stored taps.
// - Wiper registers start at 40h, mid-scale.
// - Access control register starts at 40h.
// - Wiper codes 00h..7Fh, tap rises with code.
// - New tap switch closes before old one opens.
// - Echo byte carries 111b and the address read.
// - Output passes input stream on for chained devices.
`timescale 1ns/1ns
`default_nettype none
module qwp_spi_slave (
    input  wire logic clk,     // System clock, 20 MHz
    input  wire logic srst,    // Synchronous reset, active high
    input  wire logic sck,     // Serial clock from host
    input  wire logic cs_n,    // Chip select, active low
    input  wire logic sdi,     // Serial data in
    output logic      sdo_o,   // Serial data out level
    output logic      sdo_oe,  // Serial data out enable
    output logic [qwp_pkg::NUM_CH-1:0][qwp_pkg::TAPS-1:0] tap_sw_on,  // Tap switches
    output logic      shutdown_active,  // All channels shut down
    output logic      frame_exec        // Frame executed pulse
);
    localparam int NC = qwp_pkg::NUM_CH;
    localparam int NT = qwp_pkg::TAPS;
    localparam int TW = qwp_pkg::TAP_W;
    localparam int CW = qwp_pkg::MBB_CNT_W;

    // Whole state of the system-clock side
    typedef struct packed {
        logic                        cs_prev;
        logic                        armed;
        qwp_pkg::qwp_regs_t          regs;
        qwp_pkg::qwp_mbb_t [NC-1:0]  phase;
        logic [NC-1:0][TW-1:0]       cur;
        logic [NC-1:0][TW-1:0]       tgt;
        logic [NC-1:0][CW-1:0]       cnt;
        logic [NC-1:0][NT-1:0]       sw;
        logic                        shutdown_n_bit;
        logic                        exec;
    } qwp_main_st_t;

    localparam qwp_main_st_t ST_RESET = '{
        cs_prev: 1'b1,
        armed:   1'b0,
        regs:    qwp_pkg::REGS_RESET,
        phase:   '{NC{qwp_pkg::QWP_HOLD}},
        cur:     {NC{qwp_pkg::TAP_RESET}},
        tgt:     {NC{qwp_pkg::TAP_RESET}},
        cnt:     '0,
        sw:      {NC{qwp_pkg::SW_RESET}},
        shutdown_n_bit:    1'b0,
        exec:    1'b0
    };

    qwp_main_st_t st_ff;
    qwp_main_st_t nxt_st;

    logic                cs_n_s;
    logic                cs_rise;
    logic                cs_fall;
    logic                do_exec;
    logic [2:0]          op;
    logic [4:0]          addr;
    logic [7:0]          wdata;
    qwp_pkg::qwp_frame_t frame;

    wire qwp_pkg::qwp_mbb_t [NC-1:0] ch_phase;
    wire logic [NC-1:0][TW-1:0]      ch_cur;
    wire logic [NC-1:0][TW-1:0]      ch_tgt;
    wire logic [NC-1:0][CW-1:0]      ch_cnt;
    wire logic [NC-1:0][NT-1:0]      ch_sw;

    // Chip select brought into the system clock
    qwp_sync3 #(
        .INIT (1'b1)
    ) u_cs_sync (
        .clk  (clk),
        .srst (srst),
        .din  (cs_n),
        .dout (cs_n_s)
    );

    // Serial-clock side of the link
    qwp_link u_link (
        .sck     (sck),
        .cs_n    (cs_n),
        .sdi     (sdi),
        .armed   (st_ff.armed),
        .od_mode (st_ff.regs.access_control_reg[qwp_pkg::ACR_OD_BIT]),
        .regs    (st_ff.regs),
        .frame   (frame),
        .sdo_o   (sdo_o),
        .sdo_oe  (sdo_oe)
    );

    // Chip select edges after synchronisation
    assign cs_rise = cs_n_s && !st_ff.cs_prev;
    assign cs_fall = !cs_n_s && st_ff.cs_prev;

    // execute a complete pair at deselect
    assign do_exec = cs_rise && st_ff.armed && frame.complete;

    // split the held pair into fields
    assign op    = frame.word[qwp_pkg::OP_HI:qwp_pkg::OP_LO];
    assign addr  = frame.word[qwp_pkg::ADDR_HI:qwp_pkg::ADDR_LO];
    assign wdata = frame.word[7:0];

    // Per-channel tap sequencing
    genvar c;
    generate
        for (c = 0; c < NC; c = c + 1) begin : g_ch
            qwp_pkg::qwp_mbb_t ph;
            logic [TW-1:0]     cu;
            logic [TW-1:0]     tg;
            logic [CW-1:0]     ct;
            logic [TW-1:0]     want;
            logic [NT-1:0]     sw;

            always_comb begin
                ph   = st_ff.phase[c];
                cu   = st_ff.cur[c];
                tg   = st_ff.tgt[c];
                ct   = st_ff.cnt[c];
                // tap index is the low code bits
                want = st_ff.regs.wiper_position_reg[c][TW-1:0];
                if (st_ff.shutdown_n_bit) begin
                    // follow stored code while shut down
                    ph = qwp_pkg::QWP_HOLD;
                    cu = want;
                    tg = want;
                    ct = '0;
                end else begin
                    case (st_ff.phase[c])
                        qwp_pkg::QWP_HOLD: begin
                            // start overlap on a new code
                            if (want != cu) begin
                                ph = qwp_pkg::QWP_MAKE;
                                tg = want;
                                ct = qwp_pkg::MBB_LOAD;
                            end
                        end
                        qwp_pkg::QWP_MAKE: begin
                            if (ct == '0) begin
                                ph = qwp_pkg::QWP_HOLD;
                                cu = tg;
                            end else begin
                                ct = ct - {{(CW-1){1'b0}}, 1'b1};
                            end
                        end
                        default: begin
                            ph = qwp_pkg::QWP_HOLD;
                        end
                    endcase
                end
                sw = '0;
                if (!st_ff.shutdown_n_bit) begin
                    sw = {{(NT-1){1'b0}}, 1'b1} << cu;
                    if (ph == qwp_pkg::QWP_MAKE) begin
                        sw = sw | ({{(NT-1){1'b0}}, 1'b1} << tg);
                    end
                end
            end

            assign ch_phase[c] = ph;
            assign ch_cur[c]   = cu;
            assign ch_tgt[c]   = tg;
            assign ch_cnt[c]   = ct;
            assign ch_sw[c]    = sw;
        end
    endgenerate

    // Next state: arming, register writes, channel state
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.cs_prev = cs_n_s;
        nxt_st.exec    = do_exec;
        // accept traffic after a select edge
        if (cs_fall) begin
            nxt_st.armed = 1'b1;
        end
        if (do_exec) begin
            case (op)
                qwp_pkg::OP_ACR_WR: begin
                    nxt_st.regs.access_control_reg = wdata & qwp_pkg::ACR_MASK;
                end
                qwp_pkg::OP_REG_WR: begin
                    if (addr == qwp_pkg::ADDR_ACR) begin
                        nxt_st.regs.access_control_reg = wdata & qwp_pkg::ACR_MASK;
                    end else if (addr <= qwp_pkg::ADDR_WP_LAST) begin
                        // wiper bit 7 stored as zero
                        nxt_st.regs.wiper_position_reg[addr[1:0]] =
                            wdata & qwp_pkg::WP_MASK;
                    end
                end
                default: begin
                    nxt_st.regs = st_ff.regs;
                end
            endcase
        end
        // low shutdown bit shuts every channel
        nxt_st.shutdown_n_bit  = !st_ff.regs.access_control_reg[qwp_pkg::ACR_SHUTDOWN_N_BIT_BIT];
        nxt_st.phase = ch_phase;
        nxt_st.cur   = ch_cur;
        nxt_st.tgt   = ch_tgt;
        nxt_st.cnt   = ch_cnt;
        nxt_st.sw    = ch_sw;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= ST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Registered outputs
    assign tap_sw_on       = st_ff.sw;
    assign shutdown_active = st_ff.shutdown_n_bit;
    assign frame_exec      = st_ff.exec;
endmodule
`default_nettype wire

/* src/qwp_pkg.sv */
// Shared constants and carriers for the quad wiper serial register slave
package qwp_pkg;
    // Channel and tap geometry
    localparam int NUM_CH = 4;
    localparam int TAPS   = 128;
    localparam int TAP_W  = 7;

    // Opcode field values
    localparam logic [2:0] OP_NOP    = 3'h0;
    localparam logic [2:0] OP_ACR_RD = 3'h1;
    localparam logic [2:0] OP_ACR_WR = 3'h3;
    localparam logic [2:0] OP_REG_RD = 3'h4;
    localparam logic [2:0] OP_REG_WR = 3'h6;
    localparam logic [2:0] OP_ECHO   = 3'h7;

    // Register address field values
    localparam logic [4:0] ADDR_WP_LAST = 5'h03;
    localparam logic [4:0] ADDR_ACR     = 5'h10;

    // Reset values and writable masks
    localparam logic [7:0] WP_RESET  = 8'h40;
    localparam logic [7:0] ACR_RESET = 8'h40;
    localparam logic [7:0] WP_MASK   = 8'h7F;
    localparam logic [7:0] ACR_MASK  = 8'h42;
    localparam logic [TAP_W-1:0] TAP_RESET = 7'h40;

    // Access control bit positions
    localparam int ACR_OD_BIT   = 1;
    localparam int ACR_SHUTDOWN_N_BIT_BIT = 6;

    // Word layout of an instruction/data pair
    localparam int OP_HI   = 15;
    localparam int OP_LO   = 13;
    localparam int ADDR_HI = 12;
    localparam int ADDR_LO = 8;

    // Make-before-break overlap time and its cycle count
    localparam int CLK_PERIOD_NS  = 50;
    localparam int MBB_OVERLAP_NS = 100;
    localparam int MBB_CYC = (MBB_OVERLAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MBB_CNT_W = 2;
    localparam logic [MBB_CNT_W-1:0] MBB_LOAD = MBB_CNT_W'(MBB_CYC - 1);

    // Tap switch state per channel
    typedef enum logic {QWP_HOLD, QWP_MAKE} qwp_mbb_t;

    // Register image
    typedef struct packed {
        logic [7:0]             access_control_reg;
        logic [NUM_CH-1:0][7:0] wiper_position_reg;
    } qwp_regs_t;

    // Last instruction/data pair of a frame
    typedef struct packed {
        logic [15:0] word;
        logic        complete;
    } qwp_frame_t;

    localparam qwp_regs_t REGS_RESET = '{
        access_control_reg: ACR_RESET,
        wiper_position_reg: {NUM_CH{WP_RESET}}
    };
    localparam logic [TAPS-1:0] SW_RESET = {{(TAPS-1){1'b0}}, 1'b1} << TAP_RESET;
endpackage

/* src/qwp_sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module qwp_sync3 #(
    parameter logic INIT = 1'b1
) (
    input  wire logic clk,   // System clock
    input  wire logic srst,  // Synchronous reset
    input  wire logic din,   // Asynchronous level
    output logic      dout   // Settled level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } qwp_sync_st_t;

    qwp_sync_st_t st_ff;
    qwp_sync_st_t nxt_st;

    // Shift chain, output follows on agreement
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = din;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3) begin
            nxt_st.q = st_ff.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_ff <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.q;
endmodule
`default_nettype wire

/* src/qwp_link.sv */
// Serial-clock side: shifter, read echo, daisy pass-through and output pin
`timescale 1ns/1ns
`default_nettype none
module qwp_link (
    input  wire logic              sck,      // Serial clock from host
    input  wire logic              cs_n,     // Chip select, active low
    input  wire logic              sdi,      // Serial data in
    input  wire logic              armed,    // Traffic accepted (static in frame)
    input  wire logic              od_mode,  // Open-drain output selected
    input  wire qwp_pkg::qwp_regs_t regs,    // Register image (static in frame)
    output qwp_pkg::qwp_frame_t    frame,    // Last pair, stable after frame
    output logic                   sdo_o,    // Serial data out level
    output logic                   sdo_oe    // Serial data out enable
);
    typedef struct packed {
        logic [15:0] rx;
        logic [15:0] tx;
        logic [2:0]  bit_cnt;
        logic        odd;
        logic        two;
    } qwp_link_st_t;

    qwp_link_st_t st_ff;
    qwp_link_st_t nxt_st;
    logic         started_ff;
    logic         sdo_ff;

    // Register contents for a read opcode
    function automatic logic [7:0] rd_byte(input logic [2:0] op,
                                           input logic [4:0] addr);
        rd_byte = 8'h00;
        if (op == qwp_pkg::OP_ACR_RD || addr == qwp_pkg::ADDR_ACR) begin
            rd_byte = regs.access_control_reg;
        end else if (addr <= qwp_pkg::ADDR_WP_LAST) begin
            rd_byte = regs.wiper_position_reg[addr[1:0]];
        end
    endfunction

    // Frame-start flag, cleared while deselected
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            started_ff <= 1'b0;
        end else begin
            started_ff <= 1'b1;
        end
    end

    always_comb begin
        logic [2:0] op;
        logic [4:0] addr;
        nxt_st = st_ff;
        op     = 3'h0;
        addr   = 5'h00;
        if (!started_ff) begin
            nxt_st = '0;
        end
        nxt_st.rx      = {nxt_st.rx[14:0], sdi};
        nxt_st.tx      = {nxt_st.tx[14:0], sdi};
        nxt_st.bit_cnt = nxt_st.bit_cnt + 3'h1;
        if (nxt_st.bit_cnt == 3'h0) begin
            if (nxt_st.odd) begin
                nxt_st.two = 1'b1;
                op   = nxt_st.rx[qwp_pkg::OP_HI:qwp_pkg::OP_LO];
                addr = nxt_st.rx[qwp_pkg::ADDR_HI:qwp_pkg::ADDR_LO];
                // echo and data replace outgoing pair
                if (op == qwp_pkg::OP_REG_RD || op == qwp_pkg::OP_ACR_RD) begin
                    if (op == qwp_pkg::OP_ACR_RD) begin
                        addr = qwp_pkg::ADDR_ACR;
                    end
                    nxt_st.tx = {qwp_pkg::OP_ECHO, addr, rd_byte(op, addr)};
                end
            end
            nxt_st.odd = ~nxt_st.odd;
        end
    end

    always_ff @(posedge sck) begin
        if (!cs_n) begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(negedge sck) begin
        sdo_ff <= st_ff.tx[15];
    end

    // pair counts only when byte aligned
    assign frame = {st_ff.rx, st_ff.two && (st_ff.bit_cnt == 3'h0)};

    // pin released when deselected or unarmed
    assign sdo_o  = od_mode ? 1'b0 : (started_ff & sdo_ff);
    assign sdo_oe = !cs_n && armed && (!od_mode || !(started_ff & sdo_ff));
endmodule
`default_nettype wire

/* verification/qwp_host_model.sv */
// Host model: mode 0 frames, serial clock runs only inside frames
`timescale 1ns/1ns
`default_nettype none
module qwp_host_model (
    output logic      sck,   // Serial clock
    output logic      cs_n,  // Chip select, active low
    output logic      sdi,   // Serial data to slave
    input  wire logic sdo    // Resolved serial data line
);
    // Idle levels; a short select pulse gives the slave's frame flag a known start
    initial begin
        sck  = 1'b0;
        cs_n = 1'b0;
        sdi  = 1'b0;
        #1;
        cs_n = 1'b1;
    end

    // One frame of nb bits; rx collects the sampled bits
    task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
        rx = '0;
        // host owns select, its fall opens every frame
        cs_n = 1'b0;
        #250;
        for (int i = nb - 1; i >= 0; i--) begin
            sdi = tx[i];
            #24;
            // take the bit standing before the rise, slave moves it on fall
            rx  = {rx[30:0], sdo};
            sck = 1'b1;
            #24;
            sck = 1'b0;
        end
        #250;
        // select rises to end frame, then deselect gap
        cs_n = 1'b1;
        sdi  = ~sdi;
        #2000;
    endtask
endmodule
`default_nettype wire

/* verification/qwp_spi_slave_chk.sv */
// Port assertions for the quad wiper slave
`timescale 1ns/1ns
`default_nettype none
module qwp_spi_slave_chk (
    input wire logic clk,              // System clock
    input wire logic srst,             // Synchronous reset
    input wire logic sck,              // Serial clock
    input wire logic cs_n,             // Chip select, active low
    input wire logic sdi,              // Serial data in
    input wire logic sdo_o,            // Serial data out level
    input wire logic sdo_oe,           // Serial data out enable
    input wire logic [qwp_pkg::NUM_CH-1:0][qwp_pkg::TAPS-1:0] tap_sw_on,  // Tap switches
    input wire logic shutdown_active,  // Shutdown state
    input wire logic frame_exec        // Frame executed pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // Overlap shape of a tap move on channel two
    sequence s_make;
        ($countones(tap_sw_on[2]) == 2) [*2];
    endsequence
    sequence s_one;
        $countones(tap_sw_on[2]) == 1;
    endsequence

    property p_deselect;
        cs_n |-> !sdo_oe;
    endproperty
    property p_exec_late;
        frame_exec |-> cs_n && $past(cs_n, 3);
    endproperty
    property p_exec_pulse;
        frame_exec |=> !frame_exec;
    endproperty
    property p_shutdown_n_bit_open;
        shutdown_active && $past(shutdown_active) |-> tap_sw_on == '0;
    endproperty
    property p_shutdown_n_bit_cause;
        $rose(shutdown_active) |-> $past(frame_exec) || $past(frame_exec, 2);
    endproperty
    property p_stable_frame;
        !cs_n && !$past(cs_n) |-> $stable(tap_sw_on) && $stable(shutdown_active);
    endproperty
    property p_mbb_len;
        $rose($countones(tap_sw_on[2]) == 2) |-> s_make ##1 s_one;
    endproperty
    property p_mbb(int c);
        (($past(tap_sw_on[c]) & ~tap_sw_on[c]) != '0) && !$past(shutdown_active)
            |-> (tap_sw_on[c] & $past(tap_sw_on[c])) != '0;
    endproperty
    property p_two_max(int c);
        $countones(tap_sw_on[c]) <= 2;
    endproperty

    a_deselect: assert property (p_deselect)
        else $error("output enabled while deselected");
    a_exec_late: assert property (p_exec_late)
        else $error("frame executed before select rose");
    a_exec_pulse: assert property (p_exec_pulse)
        else $error("execute pulse longer than one cycle");
    a_shutdown_n_bit_open: assert property (p_shutdown_n_bit_open)
        else $error("switch closed in shutdown");
    a_shutdown_n_bit_cause: assert property (p_shutdown_n_bit_cause)
        else $error("shutdown without executed frame");
    a_stable_frame: assert property (p_stable_frame)
        else $error("state changed inside a frame");
    a_mbb_len: assert property (p_mbb_len)
        else $error("tap overlap not two cycles");
    for (genvar c = 0; c < qwp_pkg::NUM_CH; c++) begin : g_ch
        a_mbb: assert property (p_mbb(c))
            else $error("old tap opened before new closed");
        a_two_max: assert property (p_two_max(c))
            else $error("more than two taps closed");
    end
endmodule

bind qwp_spi_slave qwp_spi_slave_chk u_qwp_spi_slave_chk (
    .clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n), .sdi(sdi),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .tap_sw_on(tap_sw_on),
    .shutdown_active(shutdown_active), .frame_exec(frame_exec));
`default_nettype wire

/* verification/tb_top.sv */
// Top bench: host model and scenarios for the quad wiper slave
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk;
    logic        srst;
    logic        sck;
    logic        cs_n;
    logic        sdi;
    logic        sdo_o;
    logic        sdo_oe;
    logic        sdo_line;
    logic        shutdown_active;
    logic        frame_exec;
    logic        od_on;
    logic [31:0] rx;
    logic [qwp_pkg::NUM_CH-1:0][qwp_pkg::TAPS-1:0] tap_sw_on;
    int          fail_count;
    int          samples_checked;
    int          cyc;
    int          od_bad;
    int          n_exec;

    // Pull-up holds the line high when nobody drives it
    assign sdo_line = sdo_oe ? sdo_o : 1'b1;

    qwp_spi_slave u_qwp_spi_slave (.clk(clk), .srst(srst), .sck(sck), .cs_n(cs_n),
        .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .tap_sw_on(tap_sw_on),
        .shutdown_active(shutdown_active), .frame_exec(frame_exec));
    qwp_host_model u_qwp_host_model (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_line));

    // 20 MHz system clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Hang guard and execute counter, sampled away from the launching edge
    always @(negedge clk) begin
        cyc = cyc + 1;
        if (frame_exec === 1'b1)
            n_exec = n_exec + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            tally_and_finish();
        end
    end

    // Open drain must never drive high
    always @(posedge sck)
        if (od_on && sdo_oe === 1'b1 && sdo_o !== 1'b0)
            od_bad = od_bad + 1;

    task automatic chk_b(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_t(input string nm, input logic [127:0] e, input logic [127:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] ins, input logic [7:0] d);
        logic [31:0] r;
        u_qwp_host_model.xfer({16'h0000, ins, d}, 16, r);
    endtask
    // Four-byte read; echo byte judged on the way
    task automatic rd(input logic [7:0] ins, input logic [4:0] a, output logic [7:0] d);
        u_qwp_host_model.xfer({ins, 24'h000000}, 32, rx);
        chk_b("echo", {qwp_pkg::OP_ECHO, a}, rx[15:8]);
        d = rx[7:0];
    endtask

    task automatic t_reset();
        logic [7:0] d;
        for (int c = 0; c < 4; c++) begin
            chk_t("tap reset", 128'h1 << qwp_pkg::TAP_RESET, tap_sw_on[c]);
            rd({qwp_pkg::OP_REG_RD, 5'(c)}, 5'(c), d);
            chk_b("wiper reset", qwp_pkg::WP_RESET, d);
        end
        rd({qwp_pkg::OP_ACR_RD, 5'h0B}, qwp_pkg::ADDR_ACR, d);
        chk_b("access reset", qwp_pkg::ACR_RESET, d);
        chk_b("shutdown", 8'h00, {7'h00, shutdown_active});
        $display("test reset done");
    endtask

    task automatic t_write();
        logic [7:0] v [4] = '{8'h00, 8'h7F, 8'hFF, 8'h33};
        logic [7:0] d;
        for (int c = 0; c < 4; c++)
            wr({qwp_pkg::OP_REG_WR, 5'(c)}, v[c]);
        for (int c = 0; c < 4; c++) begin
            rd({qwp_pkg::OP_REG_RD, 5'(c)}, 5'(c), d);
            chk_b("wiper", v[c] & 8'h7F, d);
            chk_t("tap", 128'h1 << v[c][6:0], tap_sw_on[c]);
        end
        $display("test write done");
    endtask

    task automatic t_refuse();
        logic [7:0] d;
        logic [31:0] r;
        int n0;
        n0 = n_exec;
        u_qwp_host_model.xfer(32'h000000C1, 8, r);
        u_qwp_host_model.xfer(32'h00000C1A, 12, r);
        chk_b("exec count", 8'h00, 8'(n_exec - n0));
        wr({qwp_pkg::OP_REG_WR, 5'h05}, 8'h12);
        wr({qwp_pkg::OP_NOP, 5'h01}, 8'h12);
        u_qwp_host_model.xfer(32'hC15A0000, 32, r);
        chk_b("pass lead", 8'h00, r[31:24]);
        chk_b("pass hi", 8'hC1, r[15:8]);
        chk_b("pass lo", 8'h5A, r[7:0]);
        rd({qwp_pkg::OP_REG_RD, 5'h01}, 5'h01, d);
        chk_b("wiper kept", 8'h7F, d);
        rd({qwp_pkg::OP_REG_RD, 5'h05}, 5'h05, d);
        chk_b("unmapped", 8'h00, d);
        $display("test refuse done");
    endtask

    task automatic t_od();
        logic [7:0] d;
        wr({qwp_pkg::OP_ACR_WR, 5'h07}, 8'hFF);
        od_on = 1'b1;
        rd({qwp_pkg::OP_REG_RD, qwp_pkg::ADDR_ACR}, qwp_pkg::ADDR_ACR, d);
        chk_b("access od", qwp_pkg::ACR_MASK, d);
        chk_b("od drive", 8'h00, 8'(od_bad));
        wr({qwp_pkg::OP_REG_WR, qwp_pkg::ADDR_ACR}, 8'h40);
        od_on = 1'b0;
        $display("test open drain done");
    endtask

    task automatic t_shutdown_n_bit();
        logic [7:0] d;
        wr({qwp_pkg::OP_REG_WR, qwp_pkg::ADDR_ACR}, 8'h00);
        chk_b("shutdown on", 8'h01, {7'h00, shutdown_active});
        for (int c = 0; c < 4; c++)
            chk_t("tap off", '0, tap_sw_on[c]);
        rd({qwp_pkg::OP_REG_RD, 5'h03}, 5'h03, d);
        chk_b("wiper held", 8'h33, d);
        wr({qwp_pkg::OP_ACR_WR, 5'h00}, 8'h40);
        chk_b("shutdown off", 8'h00, {7'h00, shutdown_active});
        chk_t("tap back", 128'h1 << 7'h33, tap_sw_on[3]);
        $display("test shutdown done");
    endtask

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Reset, then scenarios in order
    initial begin
        srst = 1'b1;
        od_on = 1'b0;
        fail_count = 0;
        samples_checked = 0;
        cyc = 0;
        od_bad = 0;
        n_exec = 0;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        repeat (10) @(negedge clk);
        t_reset();
        t_write();
        t_refuse();
        t_od();
        t_shutdown_n_bit();
        tally_and_finish();
    end
endmodule
`default_nettype wire
